// ---- hw/hdlc_tx_count_and_test.sv ----
// hdlc transmit length counter, soft reset, loopbacks and test functions on ahb-lite
// Behaviour
// - eight-bit transmit length counter loaded by software with next packet length.
// - at count one, the next processor transmit fifo write is tagged end of packet.
// - each processor transmit fifo write decrements a nonzero counter by one.
// - with repeat set, the programmed length reloads after each packet.
// - soft reset bit resets the controller like device reset, but stays set.
// - soft reset clears only after two zero writes or device reset.
// - rx-to-tx loopback copies received bytes and tags into transmit fifo too.
// - looped bytes are sent like processor writes, good and bad packets alike.
// - crc test shifts serial data in for sixteen receive clocks, then stops.
// - crc test expects remainder pattern f0b8 hex.
// - crc test lets every crc bit be corrupted on purpose.
// - fifo test sends transmit writes to rx fifo, rx reads to tx output.
// - fifo test passes written tags to rx fifo, shows tx output tags.
// - address test shifts serial data in for sixteen receive clocks, then stops.
// - tx-to-rx loopback routes transmit output into receive input.
// - status bit three shows receive clock gated by receiver enable.
// - status bit two shows transmit clock gated by transmitter enable.
// - status bit one high when the shifted crc compares good.
// - status bit zero high when the shifted address compares good.
// - rx fifo holds 128 bytes and flags overflow on write when full.
//
// The AHB-Lite register port was decided locally.
module hdlc_tx_count_and_test
  import htc_pkg::*;
(
  // clock, reset and enable
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // bytes from the hdlc receiver
  input  wire logic        rxByteValid,
  input  wire logic [7:0]  rxByteData,
  input  wire logic [1:0]  rxByteTag,
  // transmit fifo ports
  output logic             txFifoWrEn,
  output logic [7:0]       txFifoWrData,
  output logic [1:0]       txFifoWrTag,
  output logic             txFifoRdEn,
  input  wire logic [7:0]  txFifoRdData,
  input  wire logic [1:0]  txFifoRdTag,
  input  wire logic        txFifoEmpty,
  // serial link
  input  wire logic        rxClkPin,
  input  wire logic        rxDataPin,
  input  wire logic        txClkPin,
  input  wire logic        txSerialBit,
  output logic             rxClockToReceiver,
  output logic             rxLineToReceiver,
  output logic             controllerReset
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  htc_bus_state_t busState_q;
  logic [4:0]     busIdx_q;
  logic           busOk_q;
  logic           softRst_q;
  logic           zeroSeen_q;
  logic [6:0]     testCtrl_q;
  logic [2:0]     ctrl2_q;
  logic [7:0]     txCount_q;
  logic [7:0]     txReload_q;
  logic [15:0]    corrupt_q;
  logic [15:0]    addrExpect_q;
  logic           procPend_q;
  logic [7:0]     procPendData_q;
  logic           rxOverflow_q;
  logic [9:0]     rxMem [0:RX_DEPTH-1];
  logic [6:0]     rxWrPtr_q;
  logic [6:0]     rxRdPtr_q;
  logic [7:0]     rxCount_q;
  logic           rxClkPrev_q;
  logic           rxClkView_q;
  logic           txClkView_q;
  logic           rxClkSync;
  logic           rxDataSync;
  logic           txClkSync;
  logic           crcMatch;
  logic           addrMatch;
  logic           ctlRst;
  logic           busAccept;
  logic           addrOk;
  logic           wrStb;
  logic           rdStb;
  logic           fifoTest;
  logic           rxToTx;
  logic           txToRx;
  logic           procTxWr;
  logic           procWant;
  logic [7:0]     procData;
  logic           loopWr;
  logic           txAccept;
  logic           rxInValid;
  logic [9:0]     rxInWord;
  logic           rxPush;
  logic           rxPop;
  logic           rxFull;
  logic           rxEmpty;
  logic           rxClkSrc;
  logic           serialBit;
  logic           shiftStb;
  logic [31:0]    rdValue;

  // soft reset acts on everything except itself, the bus slave, the pin synchronisers and controllerReset
  assign ctlRst   = reset | softRst_q;
  assign fifoTest = testCtrl_q[TC_FIFO_TEST];
  assign rxToTx   = testCtrl_q[TC_RX_TO_TX];
  assign txToRx   = testCtrl_q[TC_TX_TO_RX];

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  assign busAccept = hsel && hready && htrans[HTRANS_ACT_BIT];
  assign addrOk    = (haddr[ADDR_W-1:ADDR_IDX_HI+1] == '0) &&
                     (haddr[ADDR_IDX_LO-1:0] == '0) && (hsize == HSIZE_WORD);
  assign wrStb     = (busState_q == BUS_WRITE) && busOk_q;
  assign rdStb     = (busState_q == BUS_READ) && busOk_q;

  // reads take one wait state so that hrdata comes from a flop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busState_q <= BUS_IDLE;
      busIdx_q   <= '0;
      busOk_q    <= 1'b0;
      hreadyout  <= 1'b1;
      hrdata     <= '0;
      hresp      <= 1'b0;
    end else if (clkEn) begin
      hresp <= 1'b0;
      case (busState_q)
        BUS_READ: begin
          hrdata     <= rdValue;
          hreadyout  <= 1'b1;
          busState_q <= BUS_IDLE;
        end
        BUS_IDLE, BUS_WRITE: begin
          if (busAccept) begin
            busIdx_q <= haddr[ADDR_IDX_HI:ADDR_IDX_LO];
            busOk_q  <= addrOk;
            if (hwrite) begin
              busState_q <= BUS_WRITE;
            end else begin
              busState_q <= BUS_READ;
              hreadyout  <= 1'b0;
            end
          end else begin
            busState_q <= BUS_IDLE;
          end
        end
        default: begin
          busState_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // read multiplexer; unmapped or wrong-size accesses read zero
  always_comb begin
    rdValue = '0;
    if (busOk_q) begin
      case (busIdx_q)
        IDX_FIFO_DATA: begin
          if (fifoTest) begin
            rdValue[7:0]                 = txFifoRdData;
            rdValue[FD_TAG_HI:FD_TAG_LO] = txFifoRdTag;
            rdValue[FD_EMPTY]            = txFifoEmpty;
          end else begin
            rdValue[FD_TAG_HI:0] = rxMem[rxRdPtr_q];
            rdValue[FD_EMPTY]    = rxEmpty;
          end
        end
        IDX_CTRL2:       rdValue[2:0]  = ctrl2_q;
        IDX_CRC_CORRUPT: rdValue[15:0] = corrupt_q;
        IDX_RX_STATUS: begin
          rdValue[7:0]        = rxCount_q;
          rdValue[RS_OVERFLOW] = rxOverflow_q;
        end
        IDX_ADDR_EXPECT: rdValue[15:0] = addrExpect_q;
        IDX_TX_COUNT:    rdValue[7:0]  = txCount_q;
        IDX_TEST_CTRL: begin
          rdValue[6:0]          = testCtrl_q;
          rdValue[TC_SOFT_RESET] = softRst_q;
        end
        IDX_TEST_STATUS: begin
          rdValue[TS_RX_CLK]     = rxClkView_q;
          rdValue[TS_TX_CLK]     = txClkView_q;
          rdValue[TS_CRC_MATCH]  = crcMatch;
          rdValue[TS_ADDR_MATCH] = addrMatch;
        end
        default: rdValue = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // soft reset and control registers
  // ----------------------------------------------------------------
  // only writes to test control count; one with bit seven set restarts the zero pair
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      softRst_q  <= 1'b0;
      zeroSeen_q <= 1'b0;
    end else if (clkEn && wrStb && (busIdx_q == IDX_TEST_CTRL)) begin
      if (hwdata[TC_SOFT_RESET]) begin
        softRst_q  <= 1'b1;
        zeroSeen_q <= 1'b0;
      end else if (softRst_q) begin
        if (zeroSeen_q) begin
          softRst_q  <= 1'b0;
          zeroSeen_q <= 1'b0;
        end else begin
          zeroSeen_q <= 1'b1;
        end
      end
    end
  end

  // reserved bits five and four are stored but steer nothing
  always_ff @(posedge ref_clk) begin
    if (ctlRst) begin
      testCtrl_q   <= TEST_CTRL_RST;
      ctrl2_q      <= CTRL2_RST;
      corrupt_q    <= WORD16_RST;
      addrExpect_q <= WORD16_RST;
    end else if (clkEn && wrStb) begin
      case (busIdx_q)
        IDX_TEST_CTRL:   testCtrl_q   <= hwdata[6:0];
        IDX_CTRL2:       ctrl2_q      <= hwdata[2:0];
        IDX_CRC_CORRUPT: corrupt_q    <= hwdata[15:0];
        IDX_ADDR_EXPECT: addrExpect_q <= hwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmit fifo write path and length counter
  // ----------------------------------------------------------------
  assign procTxWr = wrStb && (busIdx_q == IDX_FIFO_DATA) && !fifoTest;
  assign procWant = procTxWr || procPend_q;
  assign procData = procTxWr ? hwdata[7:0] : procPendData_q;
  assign loopWr   = rxByteValid && rxToTx && !fifoTest;
  assign txAccept = procWant && !loopWr;

  // a looped byte takes the port; a clashing processor byte waits until a cycle with no looped byte
  always_ff @(posedge ref_clk) begin
    if (ctlRst) begin
      txFifoWrEn     <= 1'b0;
      txFifoWrData   <= '0;
      txFifoWrTag    <= '0;
      procPend_q     <= 1'b0;
      procPendData_q <= '0;
    end else if (clkEn) begin
      txFifoWrEn <= 1'b0;
      if (loopWr) begin
        txFifoWrEn   <= 1'b1;
        txFifoWrData <= rxByteData;
        txFifoWrTag  <= rxByteTag;
        if (procWant) begin
          procPend_q     <= 1'b1;
          procPendData_q <= procData;
        end
      end else if (procWant) begin
        txFifoWrEn            <= 1'b1;
        txFifoWrData          <= procData;
        txFifoWrTag           <= '0;
        txFifoWrTag[TAG_EOP]  <= (txCount_q == TX_COUNT_LAST);
        procPend_q            <= 1'b0;
      end
    end
  end

  // a register write in the same cycle as a fifo write wins
  always_ff @(posedge ref_clk) begin
    if (ctlRst) begin
      txCount_q  <= TX_COUNT_RST;
      txReload_q <= TX_COUNT_RST;
    end else if (clkEn) begin
      if (wrStb && (busIdx_q == IDX_TX_COUNT)) begin
        txCount_q  <= hwdata[7:0];
        txReload_q <= hwdata[7:0];
      end else if (txAccept) begin
        if (txCount_q == TX_COUNT_LAST) begin
          txCount_q <= ctrl2_q[C2_REPEAT] ? txReload_q : TX_COUNT_RST;
        end else if (txCount_q != TX_COUNT_RST) begin
          txCount_q <= txCount_q - TX_COUNT_LAST;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  // in fifo test the receiver is locked out so only processor bytes land
  assign rxInValid = fifoTest ? (wrStb && (busIdx_q == IDX_FIFO_DATA)) : rxByteValid;
  assign rxInWord  = fifoTest ? hwdata[FD_TAG_HI:0] : {rxByteTag, rxByteData};
  assign rxFull    = (rxCount_q == RX_FULL_COUNT);
  assign rxEmpty   = (rxCount_q == '0);
  assign rxPush    = rxInValid && !rxFull;
  assign rxPop     = rdStb && (busIdx_q == IDX_FIFO_DATA) && !fifoTest && !rxEmpty;

  // storage has no reset; pointers and count define what is valid
  always_ff @(posedge ref_clk) begin
    if (clkEn && rxPush) begin
      rxMem[rxWrPtr_q] <= rxInWord;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ctlRst) begin
      rxWrPtr_q <= '0;
      rxRdPtr_q <= '0;
      rxCount_q <= '0;
    end else if (clkEn) begin
      if (rxPush) begin
        rxWrPtr_q <= rxWrPtr_q + 7'h01;
      end
      if (rxPop) begin
        rxRdPtr_q <= rxRdPtr_q + 7'h01;
      end
      case ({rxPush, rxPop})
        2'b10:   rxCount_q <= rxCount_q + 8'h01;
        2'b01:   rxCount_q <= rxCount_q - 8'h01;
        default: rxCount_q <= rxCount_q;
      endcase
    end
  end

  // sticky overflow; a new overflow in the clearing read wins
  always_ff @(posedge ref_clk) begin
    if (ctlRst) begin
      rxOverflow_q <= 1'b0;
    end else if (clkEn) begin
      if (rxInValid && rxFull) begin
        rxOverflow_q <= 1'b1;
      end else if (rdStb && (busIdx_q == IDX_RX_STATUS)) begin
        rxOverflow_q <= 1'b0;
      end
    end
  end

  // fifo test reads pop the transmit fifo instead of the receive fifo
  always_ff @(posedge ref_clk) begin
    if (ctlRst) begin
      txFifoRdEn <= 1'b0;
    end else if (clkEn) begin
      txFifoRdEn <= rdStb && (busIdx_q == IDX_FIFO_DATA) && fifoTest && !txFifoEmpty;
    end
  end

  // ----------------------------------------------------------------
  // serial side: synchronisers, loopback, clock views
  // ----------------------------------------------------------------
  htc_pin_sync u_rx_clk_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clkEn   (clkEn),
    .pinIn   (rxClkPin),
    .level_q (rxClkSync)
  );

  htc_pin_sync u_rx_data_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clkEn   (clkEn),
    .pinIn   (rxDataPin),
    .level_q (rxDataSync)
  );

  htc_pin_sync u_tx_clk_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clkEn   (clkEn),
    .pinIn   (txClkPin),
    .level_q (txClkSync)
  );

  // in tx-to-rx loopback the receiver runs from the transmit clock and data
  assign rxClkSrc  = txToRx ? txClkSync : rxClkSync;
  assign serialBit = txToRx ? txSerialBit : rxDataSync;
  assign shiftStb  = rxClkSrc && !rxClkPrev_q && ctrl2_q[C2_RX_EN];

  always_ff @(posedge ref_clk) begin
    if (ctlRst) begin
      rxClkPrev_q       <= 1'b0;
      rxClkView_q       <= 1'b0;
      txClkView_q       <= 1'b0;
      rxClockToReceiver <= 1'b0;
      rxLineToReceiver  <= 1'b0;
    end else if (clkEn) begin
      rxClkPrev_q       <= rxClkSrc;
      rxClkView_q       <= rxClkSrc && ctrl2_q[C2_RX_EN];
      txClkView_q       <= txClkSync && ctrl2_q[C2_TX_EN];
      rxClockToReceiver <= rxClkSrc;
      rxLineToReceiver  <= serialBit;
    end
  end

  // the rest of the controller follows the soft reset one cycle late
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      controllerReset <= 1'b1;
    end else if (clkEn) begin
      controllerReset <= softRst_q;
    end
  end

  // ----------------------------------------------------------------
  // crc and address comparison shifters
  // ----------------------------------------------------------------
  htc_shift_cmp u_crc_cmp (
    .ref_clk     (ref_clk),
    .clear       (ctlRst || !testCtrl_q[TC_CRC_TEST]),
    .clkEn       (clkEn),
    .shiftEn     (shiftStb),
    .bitIn       (serialBit),
    .corruptMask (corrupt_q),
    .expectWord  (CRC_EXPECT),
    .match_q     (crcMatch)
  );

  htc_shift_cmp u_addr_cmp (
    .ref_clk     (ref_clk),
    .clear       (ctlRst || !testCtrl_q[TC_ADDR_TEST]),
    .clkEn       (clkEn),
    .shiftEn     (shiftStb),
    .bitIn       (serialBit),
    .corruptMask (WORD16_RST),
    .expectWord  (addrExpect_q),
    .match_q     (addrMatch)
  );
endmodule : hdlc_tx_count_and_test

// ---- hw/htc_pin_sync.sv ----
// three-stage pin synchroniser that accepts a level once stages two and three agree
module htc_pin_sync
  import htc_pkg::*;
(
  // clock and control
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic clkEn,
  // pin and clean level
  input  wire logic pinIn,
  output logic      level_q
);
  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  // stage one feeds stage two only, so metastability never reaches logic
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
      level_q  <= 1'b0;
    end else if (clkEn) begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      if (stage2_q == stage3_q) begin
        level_q <= stage3_q;
      end
    end
  end
endmodule : htc_pin_sync

// ---- hw/htc_pkg.sv ----
// shared constants and types for the hdlc transmit count and test block
package htc_pkg;
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 32;
  localparam int          ADDR_IDX_LO     = 2;
  localparam int          ADDR_IDX_HI     = 6;
  localparam int          HTRANS_ACT_BIT  = 1;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;

  // register indices, byte address is four times the index
  localparam logic [4:0]  IDX_FIFO_DATA   = 5'h10;
  localparam logic [4:0]  IDX_CTRL2       = 5'h11;
  localparam logic [4:0]  IDX_CRC_CORRUPT = 5'h12;
  localparam logic [4:0]  IDX_RX_STATUS   = 5'h13;
  localparam logic [4:0]  IDX_ADDR_EXPECT = 5'h14;
  localparam logic [4:0]  IDX_TX_COUNT    = 5'h1a;
  localparam logic [4:0]  IDX_TEST_CTRL   = 5'h1b;
  localparam logic [4:0]  IDX_TEST_STATUS = 5'h1c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TC_SOFT_RESET = 7;
  localparam int TC_RX_TO_TX   = 6;
  localparam int TC_CRC_TEST   = 3;
  localparam int TC_FIFO_TEST  = 2;
  localparam int TC_ADDR_TEST  = 1;
  localparam int TC_TX_TO_RX   = 0;
  localparam int TS_RX_CLK     = 3;
  localparam int TS_TX_CLK     = 2;
  localparam int TS_CRC_MATCH  = 1;
  localparam int TS_ADDR_MATCH = 0;
  localparam int C2_REPEAT     = 0;
  localparam int C2_RX_EN      = 1;
  localparam int C2_TX_EN      = 2;
  localparam int FD_TAG_LO     = 8;
  localparam int FD_TAG_HI     = 9;
  localparam int FD_EMPTY      = 10;
  localparam int RS_OVERFLOW   = 8;
  localparam int TAG_EOP       = 0;

  // ----------------------------------------------------------------
  // reset values and figures
  // ----------------------------------------------------------------
  localparam logic [7:0]  TX_COUNT_RST    = 8'h00;
  localparam logic [7:0]  TX_COUNT_LAST   = 8'h01;
  localparam logic [6:0]  TEST_CTRL_RST   = 7'h00;
  localparam logic [2:0]  CTRL2_RST       = 3'h0;
  localparam logic [15:0] WORD16_RST      = 16'h0000;
  localparam logic [15:0] CRC_EXPECT      = 16'hf0b8;
  localparam logic [4:0]  CMP_SHIFTS      = 5'h10;
  localparam int          RX_DEPTH        = 128;
  localparam int          RX_PTR_W        = 7;
  localparam logic [7:0]  RX_FULL_COUNT   = 8'h80;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b10
  } htc_bus_state_t;
endpackage : htc_pkg

// ---- hw/htc_shift_cmp.sv ----
// sixteen-bit serial shift register that stops once aligned and compares to a pattern
module htc_shift_cmp
  import htc_pkg::*;
(
  // clock and control
  input  wire logic        ref_clk,
  input  wire logic        clear,
  input  wire logic        clkEn,
  // serial input
  input  wire logic        shiftEn,
  input  wire logic        bitIn,
  // comparison
  input  wire logic [15:0] corruptMask,
  input  wire logic [15:0] expectWord,
  output logic             match_q
);
  logic [15:0] shift_q;
  logic [4:0]  count_q;

  // msb first; the count freezes the shifter once the word is aligned
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      shift_q <= WORD16_RST;
      count_q <= '0;
      match_q <= 1'b0;
    end else if (clkEn) begin
      if (shiftEn && (count_q != CMP_SHIFTS)) begin
        shift_q <= {shift_q[14:0], bitIn};
        count_q <= count_q + 5'h01;
      end
      // corruption flips single bits so the checker can be proven to fail
      match_q <= (count_q == CMP_SHIFTS) && ((shift_q ^ corruptMask) == expectWord);
    end
  end
endmodule : htc_shift_cmp

// ---- tb/htc_checker_sva.sv ----
// bus and reset checks on the hdlc transmit count and test block ports
module htc_checker_sva
  import htc_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // fifo strobes and controller reset
  input wire logic        txFifoWrEn,
  input wire logic        txFifoRdEn,
  input wire logic        controllerReset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // taken requests, the soft reset writes hit index 0x1b
  logic rdTaken;
  logic wrTaken;
  logic wrTest;
  assign rdTaken = hsel && hready && htrans[HTRANS_ACT_BIT] && !hwrite;
  assign wrTaken = hsel && hready && htrans[HTRANS_ACT_BIT] && hwrite;
  assign wrTest  = wrTaken && (haddr == 32'h6c);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wrTaken |=> hreadyout)
    else $error("write stalled");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_reset_quiet: assert property ($fell(reset) |-> hreadyout && hrdata == 32'h0 &&
    !txFifoWrEn && !txFifoRdEn && controllerReset)
    else $error("outputs not quiet after reset");
  a_reset_release: assert property ($fell(reset) |=> !controllerReset)
    else $error("controller reset held after device reset");
  a_soft_cause: assert property ($rose(controllerReset) |->
    $past(wrTest, 2) || $past(wrTest, 3) || $past(wrTest, 4))
    else $error("controller reset rose without a test control write");
  a_pop_after_read: assert property (txFifoRdEn |->
    !$past(hreadyout, 1) || !$past(hreadyout, 2) || !$past(hreadyout, 3))
    else $error("tx fifo pop without a read");
  c_read: cover property (rdTaken);
  c_soft: cover property ($rose(controllerReset));
  c_push: cover property (txFifoWrEn);
endmodule : htc_checker_sva

bind hdlc_tx_count_and_test htc_checker_sva u_htc_checker_sva (.ref_clk, .reset, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .txFifoWrEn, .txFifoRdEn,
  .controllerReset);

// ---- tb/htc_link_model.sv ----
// serial link partner that clocks sixteen-bit words into the receive pins
module htc_link_model (
  // clock
  input wire logic ref_clk,
  // serial pins
  output logic     rxClkPin,
  output logic     rxDataPin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rxClkPin = 1'b0;
    rxDataPin = 1'b1;
  end
  // msb first, slow enough for the three-flop synchroniser to see every level
  task automatic send(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      rxDataPin <= w[i];
      repeat (4) @(posedge ref_clk);
      rxClkPin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rxClkPin <= 1'b0;
    end
    // clock stands still between frames, line shows the inverse of the last bit
    repeat (4) @(posedge ref_clk);
    rxDataPin <= ~w[0];
  endtask : send
endmodule : htc_link_model

// ---- tb/tb_top.sv ----
// register-level testbench for the hdlc transmit count and test block
module tb_top;
  import htc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, reset, hsel, hwrite, hreadyout, hresp, rxByteValid, txEmpty, tx_bit_clock_view;
  logic        txFifoWrEn, txFifoRdEn, rxClkPin, rxDataPin, rxClkOut, rxLineOut;
  logic        controllerReset;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans, rxByteTag, wrTag;
  logic [2:0]  hsize;
  logic [7:0]  rxByteData, wrData, headData;
  logic [9:0]  wq[$];
  int          checks, fail_count, cyc;
  hdlc_tx_count_and_test u_hdlc_tx_count_and_test (.ref_clk, .reset, .clkEn(1'b1), .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .rxByteValid, .rxByteData, .rxByteTag, .txFifoWrEn, .txFifoWrData(wrData),
    .txFifoWrTag(wrTag), .txFifoRdEn, .txFifoRdData(headData), .txFifoRdTag(2'h2),
    .txFifoEmpty(txEmpty), .rxClkPin, .rxDataPin, .txClkPin(tx_bit_clock_view), .txSerialBit(1'b0),
    .rxClockToReceiver(rxClkOut), .rxLineToReceiver(rxLineOut), .controllerReset);
  htc_link_model u_htc_link_model (.ref_clk, .rxClkPin, .rxDataPin);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // one single transfer; waits for ready in both phases, so read wait states are tolerated
  task automatic bus(input logic w, input logic [4:0] idx, input logic [31:0] wd);
    haddr <= {25'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic rd(input logic [4:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(r, exp);
  endtask : rd
  // clock, watchdog and tx fifo write monitor
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (txFifoWrEn === 1'b1)
      wq.push_back({wrTag, wrData});
    if (cyc == 6000) begin
      fail_count++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // main sequence; bits 5 and 4 of test control always written zero
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    hsel = 1'b1;
    hwrite = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    rxByteValid = 1'b0;
    rxByteData = 8'h0;
    rxByteTag = 2'h0;
    headData = 8'hc3;
    txEmpty = 1'b0;
    tx_bit_clock_view = 1'b0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(IDX_TX_COUNT, 32'h0);
    bus(1'b1, IDX_TX_COUNT, 32'h2);
    bus(1'b1, IDX_FIFO_DATA, 32'h11);
    bus(1'b1, IDX_FIFO_DATA, 32'h22);
    rd(IDX_TX_COUNT, 32'h0);
    bus(1'b1, IDX_CTRL2, 32'h3);
    bus(1'b1, IDX_TX_COUNT, 32'h1);
    bus(1'b1, IDX_FIFO_DATA, 32'h33);
    rd(IDX_TX_COUNT, 32'h1);
    chk({22'h0, wq.pop_front()}, 32'h011);
    chk({22'h0, wq.pop_front()}, 32'h122);
    chk({22'h0, wq.pop_front()}, 32'h133);
    // one byte past full; sticky flag clears on read
    for (int i = 0; i < 129; i++) begin
      rxByteValid <= 1'b1;
      rxByteData <= i[7:0];
      @(posedge ref_clk);
      rxByteValid <= 1'b0;
      @(posedge ref_clk);
    end
    rd(IDX_RX_STATUS, 32'h180);
    rd(IDX_RX_STATUS, 32'h080);
    bus(1'b1, IDX_TEST_CTRL, 32'h80);
    rd(IDX_TX_COUNT, 32'h0);
    rd(IDX_RX_STATUS, 32'h0);
    chk({31'h0, controllerReset}, 32'h1);
    bus(1'b1, IDX_TEST_CTRL, 32'h0);
    bus(1'b1, IDX_TEST_CTRL, 32'h80);
    bus(1'b1, IDX_TEST_CTRL, 32'h0);
    rd(IDX_TEST_CTRL, 32'h80);
    bus(1'b1, IDX_TEST_CTRL, 32'h0);
    rd(IDX_TEST_CTRL, 32'h0);
    bus(1'b1, IDX_TEST_CTRL, 32'h40);
    rxByteValid <= 1'b1;
    rxByteData <= 8'h5a;
    rxByteTag <= 2'h1;
    @(posedge ref_clk);
    rxByteValid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({22'h0, wq.pop_front()}, 32'h15a);
    bus(1'b1, IDX_TEST_CTRL, 32'h04);
    bus(1'b1, IDX_FIFO_DATA, 32'h1a5);
    rd(IDX_FIFO_DATA, 32'h2c3);
    txEmpty <= 1'b1;
    rd(IDX_FIFO_DATA, 32'h6c3);
    rd(IDX_RX_STATUS, 32'h2);
    tx_bit_clock_view <= 1'b1;
    bus(1'b1, IDX_CTRL2, 32'h2);
    bus(1'b1, IDX_TEST_CTRL, 32'h08);
    rd(IDX_FIFO_DATA, 32'h15a);
    rd(IDX_FIFO_DATA, 32'h1a5);
    u_htc_link_model.send(16'hf0b8);
    repeat (10) @(posedge ref_clk);
    rd(IDX_TEST_STATUS, 32'h2);
    bus(1'b1, IDX_CRC_CORRUPT, 32'h1);
    rd(IDX_TEST_STATUS, 32'h0);
    bus(1'b1, IDX_ADDR_EXPECT, 32'h1234);
    bus(1'b1, IDX_TEST_CTRL, 32'h02);
    u_htc_link_model.send(16'h1234);
    repeat (10) @(posedge ref_clk);
    rd(IDX_TEST_STATUS, 32'h1);
    bus(1'b1, IDX_CTRL2, 32'h6);
    bus(1'b1, IDX_TEST_CTRL, 32'h01);
    rd(IDX_TEST_STATUS, 32'hc);
    chk({30'h0, rxClkOut, rxLineOut}, 32'h2);
    test_done();
  end
endmodule : tb_top
